// file: hdl/hps_pkg.sv
package hps_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] HPS_REG_MODE  = 8'h01;
  localparam logic [7:0] HPS_REG_AMPL  = 8'h02;
  localparam logic [7:0] HPS_REG_LIB   = 8'h03;
  localparam logic [7:0] HPS_REG_SEQ0  = 8'h04;
  localparam logic [7:0] HPS_REG_SEQ7  = 8'h0b;
  localparam logic [7:0] HPS_REG_FIRE  = 8'h0c;
  localparam logic [7:0] HPS_REG_CTL1  = 8'h1b;
  localparam logic [7:0] HPS_REG_CTL2  = 8'h1c;
  localparam logic [7:0] HPS_REG_CTL3  = 8'h1d;
  // ==========================================================
  // field layout and values
  localparam int         HPS_STANDBY_BIT  = 6;
  localparam int         HPS_LOOP_BIT     = 7;
  localparam int         HPS_ANALOG_BIT   = 1;
  localparam logic [2:0] HPS_MODE_INT     = 3'h0;
  localparam logic [2:0] HPS_MODE_EDGE    = 3'h1;
  localparam logic [2:0] HPS_MODE_LEVEL   = 3'h2;
  localparam logic [2:0] HPS_MODE_EXTIN   = 3'h3;
  localparam logic [2:0] HPS_MODE_STREAM  = 3'h5;
  localparam logic [7:0] HPS_MODE_RESET   = 8'h40;
  localparam logic [7:0] HPS_ZERO         = 8'h00;
  localparam int         HPS_SLOTS        = 8;
  localparam int         HPS_STEP_CYCLES  = 4;
  // ==========================================================
  // timing
  localparam int HPS_CLK_MHZ        = 100;
  localparam int HPS_POWERUP_US     = 250;
  localparam int HPS_POWERUP_CYCLES = HPS_POWERUP_US * HPS_CLK_MHZ;
endpackage : hps_pkg

// file: hdl/hps_link_if.sv
`timescale 1ns/1ps
`default_nettype none
// register port plus enable and trigger pin between host and device
interface hps_link_if;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       enable_pin;
  logic       external_fire_pin;
  modport device (input wr_en, rd_en, addr, wdata, enable_pin, external_fire_pin,
                  output rdata);
  modport host (output wr_en, rd_en, addr, wdata, enable_pin, external_fire_pin,
                input rdata);
endinterface : hps_link_if
`default_nettype wire

// file: hdl/hps_device.sv
`timescale 1ns/1ps
`default_nettype none
module hps_device
  import hps_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       reset_in,
  hps_link_if.device      link,
  output logic            low_power_out,
  output logic            playing_out,
  output logic [7:0]      effect_index_out,
  output logic [7:0]      library_out,
  output logic [7:0]      drive_amplitude_out,
  output logic            closed_loop_out,
  output logic            analog_input_out
);
  typedef enum logic [2:0] {
    HPS_IDLE = 3'b001,
    HPS_PLAY = 3'b010,
    HPS_HOLD = 3'b100
  } hps_state_t;

  // ==========================================================
  // register file
  logic [7:0] mode_q, mode_d, lib_q, lib_d, ampl_q, ampl_d;
  logic [7:0] ctl_q [3], ctl_d [3];
  logic [7:0] seq_q [HPS_SLOTS], seq_d [HPS_SLOTS];
  logic       fire_q, fire_d;
  logic       trig_q, trig_d;
  hps_state_t state_q, state_d;
  logic [2:0] slot_q, slot_d;
  logic [1:0] step_q, step_d;
  logic [7:0] out_idx_q, out_idx_d, drv_q, drv_d, rdata_q, rdata_d;
  logic       low_power, start;
  logic [2:0] mode_f;

  assign mode_f    = mode_q[2:0];
  // either power-down path stops playback
  assign low_power = mode_q[HPS_STANDBY_BIT] || !link.enable_pin;

  // trigger decode per mode
  always_comb
  begin
    start = 1'b0;
    unique case (mode_f)
      HPS_MODE_INT:   start = fire_q && state_q == HPS_IDLE;
      HPS_MODE_EDGE:  start = link.external_fire_pin && !trig_q;
      HPS_MODE_LEVEL: start = link.external_fire_pin && state_q == HPS_IDLE;
      default:        start = 1'b0;
    endcase
    if (low_power)
    begin
      start = 1'b0;
    end
  end

  // register writes, fire bit and sequencer
  always_comb
  begin
    mode_d    = mode_q;
    lib_d     = lib_q;
    ampl_d    = ampl_q;
    ctl_d     = ctl_q;
    seq_d     = seq_q;
    fire_d    = fire_q;
    trig_d    = link.external_fire_pin;
    state_d   = state_q;
    slot_d    = slot_q;
    step_d    = step_q;
    out_idx_d = out_idx_q;
    rdata_d   = rdata_q;
    if (link.wr_en)
    begin
      unique case (link.addr)
        HPS_REG_MODE: mode_d = link.wdata;
        HPS_REG_AMPL: ampl_d = link.wdata;
        HPS_REG_LIB:  lib_d  = link.wdata;
        HPS_REG_FIRE: fire_d = link.wdata[0];
        HPS_REG_CTL1: ctl_d[0] = link.wdata;
        HPS_REG_CTL2: ctl_d[1] = link.wdata;
        HPS_REG_CTL3: ctl_d[2] = link.wdata;
        default:
        begin
          if (link.addr >= HPS_REG_SEQ0 && link.addr <= HPS_REG_SEQ7)
          begin
            seq_d[link.addr[2:0] - 3'h4] = link.wdata;
          end
        end
      endcase
    end
    // playback engine walks slots; a zero index ends the sequence
    unique case (state_q)
      HPS_IDLE:
      begin
        if (start)
        begin
          state_d   = HPS_PLAY;
          slot_d    = 3'h0;
          step_d    = 2'h0;
          out_idx_d = seq_q[0];
        end
      end
      HPS_PLAY:
      begin
        step_d = step_q + 2'h1;
        if (step_q == 2'(HPS_STEP_CYCLES - 1))
        begin
          if (slot_q == 3'(HPS_SLOTS - 1) || seq_q[slot_q + 3'h1] == HPS_ZERO)
          begin
            state_d = (mode_f == HPS_MODE_LEVEL) ? HPS_HOLD : HPS_IDLE;
          end
          else
          begin
            slot_d    = slot_q + 3'h1;
            out_idx_d = seq_q[slot_q + 3'h1];
          end
        end
      end
      HPS_HOLD:
      begin
        // level trigger: wait for pin release before rearming
        if (!link.external_fire_pin)
        begin
          state_d = HPS_IDLE;
        end
      end
      default: state_d = HPS_IDLE;
    endcase
    if (state_q == HPS_PLAY && state_d != HPS_PLAY)
    begin
      // a fresh fire write in the last cycle beats the self-clear, so no retrigger is lost
      if (!(link.wr_en && link.addr == HPS_REG_FIRE))
      begin
        fire_d = 1'b0; // fire bit self-clears when done
      end
      out_idx_d = HPS_ZERO;
    end
    if (low_power || mode_f > HPS_MODE_LEVEL)
    begin
      state_d   = HPS_IDLE;
      fire_d    = 1'b0;
      out_idx_d = HPS_ZERO;
    end
    // slot index is kept; replay reuses stored slots
    unique case (link.addr)
      HPS_REG_MODE: rdata_d = mode_q;
      HPS_REG_AMPL: rdata_d = ampl_q;
      HPS_REG_LIB:  rdata_d = lib_q;
      HPS_REG_FIRE: rdata_d = {7'h00, fire_q};
      HPS_REG_CTL1: rdata_d = ctl_q[0];
      HPS_REG_CTL2: rdata_d = ctl_q[1];
      HPS_REG_CTL3: rdata_d = ctl_q[2];
      default:
      begin
        rdata_d = HPS_ZERO;
        if (link.addr >= HPS_REG_SEQ0 && link.addr <= HPS_REG_SEQ7)
        begin
          rdata_d = seq_q[link.addr[2:0] - 3'h4];
        end
      end
    endcase
  end

  // drive amplitude: streamed value held while mode 5 and awake
  always_comb
  begin
    drv_d = HPS_ZERO;
    if (!low_power && mode_f == HPS_MODE_STREAM)
    begin
      drv_d = ampl_d;
    end
  end

  // ==========================================================
  // state registers
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      mode_q    <= HPS_MODE_RESET;
      lib_q     <= HPS_ZERO;
      ampl_q    <= HPS_ZERO;
      ctl_q     <= '{default: HPS_ZERO};
      seq_q     <= '{default: HPS_ZERO};
      fire_q    <= 1'b0;
      trig_q    <= 1'b0;
      state_q   <= HPS_IDLE;
      slot_q    <= 3'h0;
      step_q    <= 2'h0;
      out_idx_q <= HPS_ZERO;
      drv_q     <= HPS_ZERO;
      rdata_q   <= HPS_ZERO;
    end
    else
    begin
      mode_q    <= mode_d;
      lib_q     <= lib_d;
      ampl_q    <= ampl_d;
      ctl_q     <= ctl_d;
      seq_q     <= seq_d;
      fire_q    <= fire_d;
      trig_q    <= trig_d;
      state_q   <= state_d;
      slot_q    <= slot_d;
      step_q    <= step_d;
      out_idx_q <= out_idx_d;
      drv_q     <= drv_d;
      rdata_q   <= rdata_d;
    end
  end

  assign link.rdata          = rdata_q;
  assign low_power_out       = low_power;
  assign playing_out         = state_q == HPS_PLAY;
  assign effect_index_out    = out_idx_q;
  assign library_out         = lib_q;
  assign drive_amplitude_out = drv_q;
  // control bits default low: closed loop, pwm input
  assign closed_loop_out     = !ctl_q[2][HPS_LOOP_BIT];
  assign analog_input_out    = (mode_f == HPS_MODE_EXTIN) &&
                               ctl_q[2][HPS_ANALOG_BIT];
endmodule : hps_device
`default_nettype wire

// file: hdl/hps_host.sv
`timescale 1ns/1ps
`default_nettype none
// host end: forwards pins at once, user writes only after the power-up wait; read data comes back at any time
module hps_host
  import hps_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       reset_in,
  hps_link_if.host        link,
  input  wire logic       enable_in,
  input  wire logic       fire_pin_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  output logic            ready_out,
  output logic [7:0]      rdata_out
);
  logic [14:0] wait_q, wait_d;
  logic        ready;
  logic [7:0]  rdata_q, rdata_d;

  // access gated until power-up wait ends
  assign ready = wait_q == 15'(HPS_POWERUP_CYCLES);
  always_comb
  begin
    wait_d  = ready ? wait_q : wait_q + 15'h0001;
    rdata_d = link.rdata;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      wait_q  <= 15'h0000;
      rdata_q <= HPS_ZERO;
    end
    else
    begin
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // calibration store taken as programmed: user writes go straight through
  assign link.wr_en             = wr_in && ready;
  assign link.rd_en             = rd_in && ready;
  assign link.addr              = addr_in;
  assign link.wdata             = wdata_in;
  assign link.enable_pin        = enable_in;
  assign link.external_fire_pin = fire_pin_in;
  assign ready_out              = ready;
  assign rdata_out              = rdata_q;
endmodule : hps_host
`default_nettype wire

// file: verif/hps_link_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// link checker, sits beside the interface joining both ends
module hps_link_checker
  import hps_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       reset_in,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] rdata,
  input  wire logic       enable_pin,
  input  wire logic       external_fire_pin,
  input  wire logic       low_power_out,
  input  wire logic       playing_out,
  input  wire logic [7:0] effect_index_out,
  input  wire logic [7:0] drive_amplitude_out
);
  logic [7:0] mode_q, mode_d, slot_q, slot_d;
  logic       awake;
  // shadow of mode and first slot; without it triggers cannot be qualified
  always_comb
  begin
    mode_d = (wr_en && addr == HPS_REG_MODE) ? wdata : mode_q;
    slot_d = (wr_en && addr == HPS_REG_SEQ0) ? wdata : slot_q;
  end
  always_ff @(posedge ref_clk_in)
  begin
    mode_q <= reset_in ? HPS_MODE_RESET : mode_d;
    slot_q <= reset_in ? HPS_ZERO : slot_d;
  end
  assign awake = enable_pin && !mode_q[HPS_STANDBY_BIT];
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  // ==========================================================
  // power, mode read, playback and streaming checks
  sequence fire_wr;
    wr_en && addr == HPS_REG_FIRE && wdata[0];
  endsequence
  sequence armed(logic [2:0] m);
    awake && mode_q[2:0] == m && slot_q != HPS_ZERO && !playing_out;
  endsequence
  sequence streaming;
    awake && mode_q[2:0] == HPS_MODE_STREAM;
  endsequence
  chk_wake_mode:
    assert property (wr_en && addr == HPS_REG_MODE && wdata == HPS_ZERO
      |=> !enable_pin || !low_power_out) else $error("standby kept");
  chk_low_power:
    assert property (!enable_pin || mode_q[HPS_STANDBY_BIT] |-> low_power_out)
      else $error("not low power");
  chk_mode_read:
    assert property (rd_en && addr == HPS_REG_MODE && $past(rd_en) && !$past(wr_en)
      && $past(addr) == HPS_REG_MODE |-> rdata == mode_q) else $error("mode read");
  chk_fire_start:
    assert property (fire_wr and armed(HPS_MODE_INT) |-> ##2 playing_out)
      else $error("fire did not play");
  chk_edge_start:
    assert property (armed(HPS_MODE_EDGE) ##0 $rose(external_fire_pin)
      |-> ##[1:3] playing_out) else $error("edge did not play");
  chk_level_start:
    assert property (armed(HPS_MODE_LEVEL) ##0 $rose(external_fire_pin)
      |-> ##[1:3] playing_out) else $error("level did not play");
  chk_pin_ignored:
    assert property (armed(HPS_MODE_INT) ##0 ($rose(external_fire_pin) && !$past(wr_en))
      |=> !playing_out) else $error("pin played");
  chk_play_index:
    assert property ($rose(playing_out) |-> effect_index_out == slot_q)
      else $error("wrong first effect");
  chk_stream_follow:
    assert property (streaming ##0 (wr_en && addr == HPS_REG_AMPL)
      |=> drive_amplitude_out == $past(wdata)) else $error("amplitude");
  chk_stream_hold:
    assert property (streaming ##0 (!wr_en && $stable(mode_q) && $stable(enable_pin))
      |=> $stable(drive_amplitude_out)) else $error("amplitude moved");
endmodule : hps_link_checker
`default_nettype wire

// file: verif/hps_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// both ends joined; the bench drives the host's user side
module hps_bench
  import hps_pkg::*;
();
  logic        ref_clk_in  = 1'b0;
  logic        reset_in    = 1'b1;
  logic        enable_in   = 1'b0;
  logic        fire_pin_in = 1'b0;
  logic        wr_in       = 1'b0;
  logic        rd_in       = 1'b0;
  logic [7:0]  addr_in     = 8'h00;
  logic [7:0]  wdata_in    = 8'h00;
  logic        ready_out, playing_out, low_power_out, closed_loop_out, analog_input_out;
  logic [7:0]  rdata_out, effect_index_out, library_out, drive_amplitude_out, v;
  int          failures     = 0;
  int          total_checks = 0;
  int          n;
  // rows: address, value written, value read back
  logic [23:0] rows [8] = '{{HPS_REG_LIB, 8'h03, 8'h03}, {8'h05, 8'h22, 8'h22},
    {HPS_REG_SEQ7, 8'h5a, 8'h5a}, {HPS_REG_CTL1, 8'h12, 8'h12}, {HPS_REG_CTL2, 8'h34, 8'h34},
    {HPS_REG_CTL3, 8'h82, 8'h82}, {HPS_REG_AMPL, 8'h44, 8'h44}, {8'h20, 8'h77, 8'h00}};
  hps_link_if link ();
  hps_host i_hps_host (.ref_clk_in, .reset_in, .link, .enable_in, .fire_pin_in, .wr_in,
    .rd_in, .addr_in, .wdata_in, .ready_out, .rdata_out);
  hps_device i_hps_device (.ref_clk_in, .reset_in, .link, .low_power_out, .playing_out,
    .effect_index_out, .library_out, .drive_amplitude_out, .closed_loop_out,
    .analog_input_out);
  hps_link_checker i_hps_link_checker (.ref_clk_in, .reset_in, .wr_en(link.wr_en),
    .rd_en(link.rd_en), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
    .enable_pin(link.enable_pin), .external_fire_pin(link.external_fire_pin),
    .low_power_out, .playing_out, .effect_index_out, .drive_amplitude_out);
  always #5 ref_clk_in = ~ref_clk_in;
  // ==========================================================
  // shared tasks
  task conclude();
    if (failures == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  task check(input logic [7:0] got, input logic [7:0] want);
    total_checks++;
    if (got !== want)
    begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, got, want);
    end
  endtask : check
  task flag(input logic got, input logic want);
    check({7'h00, got}, {7'h00, want});
  endtask : flag
  task step(input int k);
    repeat (k) @(posedge ref_clk_in);
    #1;
  endtask : step
  // one-cycle write strobe, then settle time before looking at outputs
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
    step(3);
  endtask : wr
  // read held long enough to cover host and device latency
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    repeat (4) @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1;
    d = rdata_out;
  endtask : rd
  // pin changes only on the rising edge
  task pulse();
    @(posedge ref_clk_in);
    fire_pin_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    fire_pin_in <= 1'b0;
    step(1);
  endtask : pulse
  task await(input logic want);
    int k;
    for (k = 0; k < 200 && playing_out !== want; k++) step(1);
    if (k == 200)
    begin
      failures++;
      conclude();
    end
  endtask : await
  // ==========================================================
  // main sequence
  initial
  begin
    repeat (3) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    step(1);
    flag(low_power_out, 1'b1);
    flag(closed_loop_out, 1'b1);
    flag(ready_out, 1'b0);
    for (n = 0; n < 30000 && ready_out !== 1'b1; n++) step(1);
    flag(n >= HPS_POWERUP_CYCLES - 8, 1'b1);
    if (ready_out !== 1'b1)
    begin
      failures++;
      conclude();
    end
    @(posedge ref_clk_in);
    enable_in <= 1'b1;
    step(1);
    flag(low_power_out, 1'b1);
    wr(HPS_REG_MODE, HPS_ZERO);
    flag(low_power_out, 1'b0);
    rd(HPS_REG_MODE, v);
    check(v, HPS_ZERO);
    for (n = 0; n < 8; n++)
    begin
      wr(rows[n][23:16], rows[n][15:8]);
      rd(rows[n][23:16], v);
      check(v, rows[n][7:0]);
    end
    check(library_out, 8'h03);
    flag(closed_loop_out, 1'b0);
    wr(HPS_REG_SEQ0, 8'h11);
    // fire twice without touching the slots: the replay must match
    for (n = 0; n < 2; n++)
    begin
      wr(HPS_REG_FIRE, 8'h01);
      await(1'b1);
      check(effect_index_out, 8'h11);
      step(4);
      check(effect_index_out, 8'h22);
      await(1'b0);
      rd(HPS_REG_FIRE, v);
      check(v, HPS_ZERO);
    end
    pulse();
    flag(playing_out, 1'b0);
    for (n = 1; n < 3; n++)
    begin
      wr(HPS_REG_MODE, 8'(n));
      pulse();
      await(1'b1);
      check(effect_index_out, 8'h11);
      await(1'b0);
    end
    wr(HPS_REG_MODE, {5'h00, HPS_MODE_STREAM});
    wr(HPS_REG_AMPL, 8'h7f);
    check(drive_amplitude_out, 8'h7f);
    step(5);
    check(drive_amplitude_out, 8'h7f);
    wr(HPS_REG_AMPL, 8'h80);
    check(drive_amplitude_out, 8'h80);
    // enable low alone, standby clear, must still mean low power
    @(posedge ref_clk_in);
    enable_in <= 1'b0;
    step(1);
    flag(low_power_out, 1'b1);
    @(posedge ref_clk_in);
    enable_in <= 1'b1;
    wr(HPS_REG_MODE, {5'h00, HPS_MODE_EXTIN});
    flag(analog_input_out, 1'b1);
    wr(HPS_REG_MODE, 8'h45);
    flag(low_power_out, 1'b1);
    conclude();
  end
endmodule : hps_bench
`default_nettype wire
